// File: design/isr_status.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"
module isr_status
  import isr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Instrument events and status
  input wire logic [7:0] std_event,
  input wire logic [7:0] oper_cond,
  // Message characters from the listener
  input wire logic rx_valid,
  input wire logic [7:0] rx_char,
  output logic msg_done,
  output logic msg_common,
  output logic msg_query,
  // Talker side
  input wire logic talk,
  output logic resp_valid,
  output logic [7:0] resp_data,
  // Service request line, open drain
  output logic srq_o,
  output logic srq_oe
);

  // ***************
  // Reset release
  // ***************
  logic rst_a_q;
  logic rst_n_q;

  // Two stages so the release is clean to clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_a_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n_q <= rst_a_q;
    end
  end

  // ***************
  // Register storage
  // ***************
  isr_byte_t sev_q;
  isr_byte_t sen_q;
  isr_byte_t oev_q;
  isr_byte_t oen_q;
  isr_byte_t sre_q;
  isr_byte_t ocn_q;
  logic pon_q;
  logic wr_sre, wr_sen, wr_oen, rd_sev, rd_oev, cls;
  logic ses, ops, mss;
  isr_byte_t stb;
  isr_byte_t oev_rise;
  isr_byte_t rd_val;
  logic cme_len;

  // Strobe decode
  assign wr_sre = wr && addr == `ISR_A_SRE;
  assign wr_sen = wr && addr == `ISR_A_SEN;
  assign wr_oen = wr && addr == `ISR_A_OEN;
  assign rd_sev = rd && addr == `ISR_A_SEV; // [RQ11]
  assign rd_oev = rd && addr == `ISR_A_OEV; // [RQ11]
  assign cls = wr && addr == `ISR_A_CMD && wdata[`ISR_CMD_CLS]; // [RQ22]

  // Condition copy; no storage beyond one sample
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ocn_q <= `ISR_RST_VAL;
    end else begin
      ocn_q <= oper_cond; // [RQ8]
    end
  end

  // Operation events fire on condition rising edges
  assign oev_rise = oper_cond & ~ocn_q;

  // Power-on marker, one shot after reset release
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pon_q <= 1'b1;
    end else begin
      pon_q <= 1'b0;
    end
  end

  // Standard event register; set wins over clear
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sev_q <= `ISR_RST_VAL; // [RQ24]
    end else begin
      sev_q <= ((rd_sev || cls) ? 8'h00 : sev_q) // [RQ11] [RQ22]
        | std_event // [RQ10]
        | ({7'h00, pon_q} << `ISR_SE_PON) // [RQ21] [RQ24]
        | ({7'h00, cme_len} << `ISR_SE_CME); // [RQ21]
    end
  end

  // Operation event register; repeats while set do nothing
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      oev_q <= `ISR_RST_VAL;
    end else begin
      oev_q <= ((rd_oev || cls) ? 8'h00 : oev_q) | oev_rise; // [RQ10] [RQ11]
    end
  end

  // Enable registers, only writable storage
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sen_q <= `ISR_RST_VAL; // [RQ24]
      oen_q <= `ISR_RST_VAL;
      sre_q <= `ISR_RST_VAL;
    end else begin
      if (wr_sen) begin
        sen_q <= wdata; // [RQ13] [RQ19]
      end
      if (wr_oen) begin
        oen_q <= wdata; // [RQ13]
      end
      if (wr_sre) begin
        sre_q <= wdata & ~(8'h01 << `ISR_STB_MSS); // [RQ17] [RQ23]
      end
    end
  end

  // ***************
  // Summaries
  // ***************
  // Live, so clearing an event drops its summary at once
  assign ses = |(sev_q & sen_q); // [RQ12]
  assign ops = |(oev_q & oen_q); // [RQ12]
  always_comb begin
    stb = 8'h00;
    stb[`ISR_STB_SES] = ses; // [RQ20]
    stb[`ISR_STB_OPS] = ops;
    mss = |(stb & sre_q); // [RQ15]
    stb[`ISR_STB_MSS] = mss; // [RQ14] [RQ16] [RQ23]
  end

  // Service request pin, driven low only
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      srq_oe <= 1'b0;
    end else begin
      srq_oe <= mss; // [RQ15]
    end
  end
  assign srq_o = 1'b0;

  // ***************
  // Read path
  // ***************
  // Read mux; unmapped and write-only addresses give zero
  always_comb begin
    case (addr)
      `ISR_A_STB: rd_val = stb; // [RQ14]
      `ISR_A_SRE: rd_val = sre_q;
      `ISR_A_SEV: rd_val = sev_q;
      `ISR_A_SEN: rd_val = sen_q;
      `ISR_A_OCN: rd_val = oper_cond; // [RQ8] [RQ9]
      `ISR_A_OEV: rd_val = oev_q;
      `ISR_A_OEN: rd_val = oen_q;
      default: rd_val = 8'h00;
    endcase
  end

  // Read data one cycle after strobe, binary weighted
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rd_val; // [RQ18]
    end
  end

  // ***************
  // Reply holding
  // ***************
  logic pend_q;

  // Newer query overwrites older; sent only on talk
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pend_q <= 1'b0;
      resp_data <= 8'h00;
      resp_valid <= 1'b0;
    end else begin
      resp_valid <= talk && pend_q; // [RQ5]
      if (rd) begin
        resp_data <= rd_val; // [RQ6]
        pend_q <= 1'b1;
      end else if (talk) begin
        pend_q <= 1'b0;
      end
    end
  end

  // ***************
  // Message framing
  // ***************
  isr_pstate_e pst_q;
  logic [8:0] len_q;
  logic last_q_q;
  logic term;

  // Semicolon or line end closes one string
  assign term = rx_char == `ISR_CH_SEMI || rx_char == `ISR_CH_LF
    || rx_char == `ISR_CH_CR; // [RQ1] [RQ3]

  // Classify each string: common on its first character, query as it closes
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pst_q <= ISR_IDLE;
      msg_common <= 1'b0;
      msg_query <= 1'b0;
      msg_done <= 1'b0;
      last_q_q <= 1'b0;
    end else begin
      msg_done <= 1'b0;
      if (rx_valid) begin
        case (pst_q)
          ISR_IDLE: begin
            if (!term) begin
              pst_q <= ISR_BODY;
              msg_common <= rx_char == `ISR_CH_STAR; // [RQ7]
              last_q_q <= rx_char == `ISR_CH_QUEST;
            end
          end
          ISR_BODY: begin
            if (term) begin
              pst_q <= ISR_IDLE;
              msg_done <= 1'b1;
              msg_query <= last_q_q; // [RQ4] [RQ7]
            end else if (rx_char != 8'h20) begin
              last_q_q <= rx_char == `ISR_CH_QUEST;
            end
          end
          default: pst_q <= ISR_IDLE;
        endcase
      end
    end
  end

  // Length guard across a whole transmission
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      len_q <= 9'h000;
    end else if (rx_valid) begin
      if (rx_char == `ISR_CH_LF) begin
        len_q <= 9'h000;
      end else if (len_q <= 9'(`ISR_MAX_LEN)) begin
        len_q <= len_q + 9'h001;
      end
    end
  end
  // Overlong transmission counts as a command error, flagged once
  assign cme_len = rx_valid && rx_char != `ISR_CH_LF
    && len_q == 9'(`ISR_MAX_LEN); // [RQ2]

  // ***************
  // Checks
  // ***************
  property p_latch;
    @(posedge clk) disable iff (!rst_n_q)
    (!rd_sev && !cls) |=> (sev_q & $past(sev_q)) == $past(sev_q);
  endproperty
  a_latch: assert property (p_latch) else $error("event bit lost"); // [RQ11]

  property p_clear;
    @(posedge clk) disable iff (!rst_n_q)
    cls && std_event == 8'h00 && !cme_len && oev_rise == 8'h00
      |=> sev_q == 8'h00 && oev_q == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed"); // [RQ22]

  property p_set;
    @(posedge clk) disable iff (!rst_n_q)
    std_event[4] |=> sev_q[4];
  endproperty
  a_set: assert property (p_set) else $error("event not set"); // [RQ10]

  property p_sum;
    @(posedge clk) disable iff (!rst_n_q)
    stb[5] == |(sev_q & sen_q) && stb[7] == |(oev_q & oen_q);
  endproperty
  a_sum: assert property (p_sum) else $error("summary wrong"); // [RQ12]

  property p_srq;
    @(posedge clk) disable iff (!rst_n_q)
    ##1 srq_oe == $past(|({stb[7], 1'b0, stb[5:0]} & sre_q));
  endproperty
  a_srq: assert property (p_srq) else $error("srq wrong"); // [RQ15]

  property p_sen_rb;
    @(posedge clk) disable iff (!rst_n_q)
    wr_sen ##1 !wr ##1 (rd && addr == `ISR_A_SEN && !wr) |=> rdata == $past(wdata, 3);
  endproperty
  a_sen_rb: assert property (p_sen_rb) else $error("enable readback"); // [RQ13]

  property p_sre6;
    @(posedge clk) disable iff (!rst_n_q)
    !sre_q[6];
  endproperty
  a_sre6: assert property (p_sre6) else $error("sre bit 6 set"); // [RQ23]

  property p_talk;
    @(posedge clk) disable iff (!rst_n_q)
    resp_valid |-> $past(talk);
  endproperty
  a_talk: assert property (p_talk) else $error("reply without talk"); // [RQ5]

  property p_pon;
    @(posedge clk) disable iff (!rstn)
    $rose(rst_n_q) |=> sev_q[7];
  endproperty
  a_pon: assert property (p_pon) else $error("power-on missing"); // [RQ24]

  // Every rising condition must leave its event bit set
  property p_oev_set;
    @(posedge clk) disable iff (!rst_n_q)
    oev_rise != 8'h00 |=> (oev_q & $past(oev_rise)) == $past(oev_rise);
  endproperty
  a_oev_set: assert property (p_oev_set) else $error("operation event not set"); // [RQ10]

  // Condition read shows the live level, nothing latched
  property p_ocn_live;
    @(posedge clk) disable iff (!rst_n_q)
    rd && addr == `ISR_A_OCN |=> rdata == $past(oper_cond);
  endproperty
  a_ocn_live: assert property (p_ocn_live) else $error("condition read stale"); // [RQ8]

  // Leading asterisk marks the string as common
  property p_common;
    @(posedge clk) disable iff (!rst_n_q)
    rx_valid && pst_q == ISR_IDLE && rx_char == `ISR_CH_STAR |=> msg_common;
  endproperty
  a_common: assert property (p_common) else $error("common not flagged"); // [RQ7]

endmodule // isr_status
`default_nettype wire

// File: design/isr_defs.svh
`ifndef ISR_DEFS_SVH
`define ISR_DEFS_SVH
// Behaviour
// [RQ1] Controller chains strings with semicolons
// [RQ2] Whole transmission at most 255 characters
// [RQ3] Command: mnemonic, space, data, terminator
// [RQ4] Query adds question mark after mnemonic
// [RQ5] Reply only when addressed to talk
// [RQ6] Only newest pending reply is sent
// [RQ7] Asterisk marks common, question mark query
// [RQ8] Condition bits live, read only
// [RQ9] Standard set has no condition register
// [RQ10] Event bit latches, repeats ignored
// [RQ11] Event bit held until read or clear
// [RQ12] Summary is OR of event AND enable
// [RQ13] Enable registers read back last write
// [RQ14] Status byte read only, not latched
// [RQ15] Master summary from status and request enable
// [RQ16] Status byte read shows master summary
// [RQ17] Request enable register read and write
// [RQ18] Reads return binary weighted eight bits
// [RQ19] Only enable registers accept writes; the code also acts on a clear-status write to the command address
// [RQ20] Standard summary at status bit 5
// [RQ21] Standard event bit positions fixed
// [RQ22] Clear status clears both event registers
// [RQ23] Master summary at bit 6, masked
// [RQ24] Reset clears, then power-on flagged

// ***************
// Register map
// ***************
`define ISR_A_STB 4'h0
`define ISR_A_SRE 4'h1
`define ISR_A_SEV 4'h2
`define ISR_A_SEN 4'h3
`define ISR_A_OCN 4'h4
`define ISR_A_OEV 4'h5
`define ISR_A_OEN 4'h6
`define ISR_A_CMD 4'h7
`define ISR_CMD_CLS 0

// ***************
// Bit positions
// ***************
`define ISR_STB_SES 5
`define ISR_STB_MSS 6
`define ISR_STB_OPS 7
`define ISR_SE_PON 7
`define ISR_SE_CME 5
`define ISR_SE_EXE 4
`define ISR_SE_QYE 2
`define ISR_SE_OPC 0
`define ISR_RST_VAL 8'h00

// ***************
// Message characters
// ***************
`define ISR_CH_STAR 8'h2A
`define ISR_CH_QUEST 8'h3F
`define ISR_CH_SEMI 8'h3B
`define ISR_CH_LF 8'h0A
`define ISR_CH_CR 8'h0D
`define ISR_MAX_LEN 255
`endif

// File: design/isr_pkg.sv
package isr_pkg;
  typedef logic [3:0] isr_addr_t;
  typedef logic [7:0] isr_byte_t;
  typedef enum logic [0:0] {
    ISR_IDLE = 1'b0,
    ISR_BODY = 1'b1
  } isr_pstate_e;
endpackage

// File: verif/isr_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Controller model
// ****************
module isr_ctrl_model (
  // Clock
  input wire logic clk,
  // Listener and talker strobes
  output var logic rx_valid,
  output var logic [7:0] rx_char,
  output var logic talk
);
  // Quiet lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_char = 8'h00;
    talk = 1'b0;
  end
  // One char per strobe; idle shows inverse so no stale copy lingers
  task automatic put(input logic [7:0] c);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_char <= c;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask
  // Whole string, short, ending in its own terminator
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      put(s[i]);
    end
  endtask
  // Address the device to talk
  task automatic ask();
    @(posedge clk);
    talk <= 1'b1;
    @(posedge clk);
    talk <= 1'b0;
  endtask
endmodule // isr_ctrl_model
`default_nettype wire

// File: verif/isr_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "isr_defs.svh"
module isr_status_tb import isr_pkg::*;;
  // ****************
  // Bench
  // ****************
  logic clk, rstn, wr, rd, rx_valid, talk;
  logic msg_done, msg_common, msg_query, resp_valid, srq_o, srq_oe;
  isr_addr_t addr;
  isr_byte_t wdata, rdata, std_event, oper_cond, rx_char, resp_data;
  int failures = 0;
  int checks = 0;
  isr_status dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .std_event(std_event), .oper_cond(oper_cond),
    .rx_valid(rx_valid), .rx_char(rx_char), .msg_done(msg_done),
    .msg_common(msg_common), .msg_query(msg_query), .talk(talk),
    .resp_valid(resp_valid), .resp_data(resp_data), .srq_o(srq_o), .srq_oe(srq_oe));
  isr_ctrl_model u_ctl (.clk(clk), .rx_valid(rx_valid), .rx_char(rx_char), .talk(talk));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input isr_addr_t a, input isr_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data stand from the cycle after the strobe until the next read
  task automatic rd_reg(input isr_addr_t a, input isr_byte_t exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic fire(input isr_byte_t v);
    @(posedge clk);
    std_event <= v;
    @(posedge clk);
    std_event <= 8'h00;
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    print_verdict();
  end
  // Main sequence
  initial begin
    rstn = 1'b0;
    {addr, wdata, wr, rd, std_event, oper_cond} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(`ISR_A_SEV, 8'h80);
    rd_reg(`ISR_A_SEV, 8'h00);
    rd_reg(`ISR_A_SRE, 8'h00);
    rd_reg(`ISR_A_OEN, 8'h00);
    wr_reg(`ISR_A_SEN, 8'h35);
    rd_reg(`ISR_A_SEN, 8'h35);
    wr_reg(`ISR_A_SRE, 8'hFF);
    rd_reg(`ISR_A_SRE, 8'hBF);
    wr_reg(`ISR_A_SEV, 8'hFF);
    wr_reg(`ISR_A_STB, 8'hFF);
    rd_reg(`ISR_A_SEV, 8'h00);
    rd_reg(`ISR_A_STB, 8'h00);
    fire(8'h10);
    fire(8'h10);
    rd_reg(`ISR_A_STB, 8'h60);
    chk({7'h00, srq_oe}, 8'h01);
    rd_reg(`ISR_A_SEV, 8'h10);
    rd_reg(`ISR_A_STB, 8'h00);
    @(posedge clk);
    oper_cond <= 8'h05;
    wr_reg(`ISR_A_OEN, 8'h01);
    rd_reg(`ISR_A_OCN, 8'h05);
    rd_reg(`ISR_A_STB, 8'hC0);
    fire(8'h01);
    wr_reg(`ISR_A_CMD, 8'h01);
    rd_reg(`ISR_A_STB, 8'h00);
    rd_reg(`ISR_A_SEV, 8'h00);
    rd_reg(`ISR_A_OEV, 8'h00);
    chk({7'h00, srq_oe}, 8'h00);
    @(posedge clk);
    oper_cond <= 8'h00;
    rd_reg(`ISR_A_OCN, 8'h00);
    rd_reg(4'hF, 8'h00);
    // Reply path: only the newest read is answered
    u_ctl.ask();
    #1;
    chk({7'h00, resp_valid}, 8'h01);
    chk(resp_data, 8'h00);
    rd_reg(`ISR_A_SEN, 8'h35);
    rd_reg(`ISR_A_SRE, 8'hBF);
    chk({7'h00, resp_valid}, 8'h00);
    u_ctl.ask();
    #1;
    chk({resp_valid, 7'h00}, 8'h80);
    chk(resp_data, 8'hBF);
    u_ctl.ask();
    #1;
    chk({7'h00, resp_valid}, 8'h00);
    // Message framing
    u_ctl.send("*CLS\n");
    #1;
    chk({5'h00, msg_done, msg_common, msg_query}, 8'h06);
    // One chained transmission, closed by its line end
    u_ctl.send("*X?;");
    #1;
    chk({5'h00, msg_done, msg_common, msg_query}, 8'h07);
    u_ctl.send("A?\n");
    #1;
    chk({5'h00, msg_done, msg_common, msg_query}, 8'h05);
    chk({7'h00, srq_o}, 8'h00);
    print_verdict();
  end
endmodule // isr_status_tb
`default_nettype wire
